// [hw/dtc_pkg.sv]
// package: register map, field positions and timing constants of the timer pair
package dtc_pkg;

  // special-function-register addresses
  localparam logic [7:0] DTC_ADDR_CTRL  = 8'h88; // timer_control_reg
  localparam logic [7:0] DTC_ADDR_MODE  = 8'h89; // timer_mode_reg
  localparam logic [7:0] DTC_ADDR_TL0   = 8'h8a; // timer0_low_byte
  localparam logic [7:0] DTC_ADDR_TL1   = 8'h8b; // timer1_low_byte
  localparam logic [7:0] DTC_ADDR_TH0   = 8'h8c; // timer0_high_byte
  localparam logic [7:0] DTC_ADDR_TH1   = 8'h8d; // timer1_high_byte
  localparam logic [7:0] DTC_ADDR_PRESC = 8'h8e; // timer_prescale_select
  localparam logic [7:0] DTC_ADDR_PCFG  = 8'h96; // port 3 config, toggle enables

  // reset values
  localparam logic [7:0] DTC_RST_BYTE = 8'h00;

  // timer_mode_reg fields, per timer nibble (timer 1 adds 4)
  localparam int DTC_MODE_NIB   = 4;
  localparam int DTC_MODE_LO    = 0; // mode_select_low
  localparam int DTC_MODE_HI    = 1; // mode_select_high
  localparam int DTC_MODE_CT    = 2; // counter (1) / timer (0)
  localparam int DTC_MODE_GATE  = 3; // gate on external interrupt pin

  // timer_control_reg fields
  localparam int DTC_CTRL_RUN0  = 4; // timer0_run
  localparam int DTC_CTRL_OVF0  = 5; // timer0_overflow_flag
  localparam int DTC_CTRL_RUN1  = 6; // timer1_run
  localparam int DTC_CTRL_OVF1  = 7; // timer1_overflow_flag

  // timer_prescale_select fields
  localparam int DTC_PRESC_FAST0 = 3; // timer0_fast_prescale
  localparam int DTC_PRESC_FAST1 = 4; // timer1_fast_prescale

  // port config fields
  localparam int DTC_PCFG_TOE0  = 2; // timer0_toggle_out_enable
  localparam int DTC_PCFG_TOE1  = 3; // timer1_toggle_out_enable

  // machine cycle: twelve clocks, phases 0..11
  localparam logic [3:0] DTC_PH_LAST   = 4'hb;
  localparam logic [3:0] DTC_PH_UPDATE = 4'h3; // count registers update here
  localparam logic [3:0] DTC_PH_SAMPLE = 4'h4; // count pins sampled here
  localparam logic [1:0] DTC_PH_FAST   = 2'h3; // every fourth clock
  localparam int         DTC_LOW_PRE   = 5;    // prescaler width in mode 0

  // operating modes
  typedef enum logic [1:0] {
    DTC_M13   = 2'b00, // 8-bit count over 5-bit prescaler
    DTC_M16   = 2'b01, // 16-bit count
    DTC_M8R   = 2'b11, // 8-bit auto-reload (encoded 10, see decode)
    DTC_MSPL  = 2'b10  // split timer 0 / timer 1 halted (encoded 11)
  } dtc_mode_t;

  // processor special-function-register access
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } dtc_sfr_req_t;

endpackage

// [hw/dtc_core.sv]
// dual 16-bit timer/counter core reached over the special-function registers
// Notes on behaviour
// - each count is high plus low byte register
// - toggle enable inverts count pin on overflow
// - counter function counts count-pin falling edges
// - pins sampled once per machine cycle, high-then-low
// - counts update at fixed phase, edge next cycle
// - counter select at mode bits 2 and 6
// - four modes per timer, own select bits
// - timer ticks every 12 clocks, or 4
// - prescale bit 4 sets timer 1 rate
// - prescale bit 3 sets timer 0 rate
// - modes: 13-bit, 16-bit, reload, split/halt
// - gate bit adds external interrupt pin high
// - overflow flag set, cleared on service, writable
`timescale 1ns/100ps
`default_nettype none

module dtc_core
  import dtc_pkg::*;
(
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rst_b,
  input  wire logic         clk_en,
  // processor register access
  input  wire dtc_sfr_req_t sfr_req,
  output var  logic [7:0]   sfr_rdata,
  // interrupt service entry, one pulse per timer
  input  wire logic [1:0]   ovf_service_ack,
  output var  logic [1:0]   ovf_flag,
  // count pins (two-way) and external interrupt pins
  input  wire logic [1:0]   count_pin_in,
  output var  logic [1:0]   count_pin_out,
  output var  logic [1:0]   count_pin_oe,
  input  wire logic [1:0]   ext_irq_pin
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] tl_r [2];        // low byte of each count
  logic [7:0] th_r [2];        // high byte of each count
  logic [7:0] mode_r;          // timer_mode_reg
  logic [1:0] run_r;           // run bits
  logic [1:0] ovf_r;           // overflow flags
  logic [1:0] fast_r;          // fast prescale selects
  logic [1:0] toe_r;           // toggle output enables
  logic [1:0] tog_r;           // toggle latches on the count pins
  logic [3:0] phase_r;         // machine-cycle phase
  logic [3:0] sync1_r;         // first synchroniser stage
  logic [3:0] sync2_r;         // second synchroniser stage
  logic [1:0] samp_r;          // count pin sample of this machine cycle
  logic [1:0] pend_r;          // recognised falling edge awaiting update
  logic [7:0] rdata_r;         // registered read data

  ////////////////////////////////////////////////////////////////////////////
  // machine-cycle phase counter
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      phase_r <= '0;
    end else if (clk_en) begin
      phase_r <= (phase_r == DTC_PH_LAST) ? '0 : phase_r + 4'h1;
    end
  end

  logic at_update;             // once per machine cycle
  logic at_sample;             // once per machine cycle
  logic at_fast;               // every fourth clock
  assign at_update = (phase_r == DTC_PH_UPDATE);
  assign at_sample = (phase_r == DTC_PH_SAMPLE);
  assign at_fast   = (phase_r[1:0] == DTC_PH_FAST);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: only stage two is read downstream
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else if (clk_en) begin
      sync1_r <= {ext_irq_pin, count_pin_in};
      sync2_r <= sync1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // count pin sampling and falling-edge recognition
  // a pulse shorter than one machine cycle may be missed; the source
  // must keep edges no faster than clock/24
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      samp_r <= '0;
      pend_r <= '0;
    end else if (clk_en) begin
      if (at_sample) begin
        samp_r <= sync2_r[1:0];
        pend_r <= samp_r & ~sync2_r[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-timer count enables
  logic [1:0] is_ctr;          // counter function selected
  logic [1:0] gate;            // gate bits
  logic [1:0] run_ok;          // run and gate condition
  logic [1:0] tick;            // timer-function tick
  logic [1:0] inc;             // increment this clock
  dtc_mode_t  mode [2];        // decoded modes

  // the mode pair is remapped so the enum keeps a gray path
  function automatic dtc_mode_t dec_mode(input logic [1:0] sel);
    case (sel)
      2'b00:   dec_mode = DTC_M13;
      2'b01:   dec_mode = DTC_M16;
      2'b10:   dec_mode = DTC_M8R;
      default: dec_mode = DTC_MSPL;
    endcase
  endfunction

  for (genvar i = 0; i < 2; i++) begin : g_en
    assign mode[i]   = dec_mode({mode_r[i*DTC_MODE_NIB+DTC_MODE_HI],
                                 mode_r[i*DTC_MODE_NIB+DTC_MODE_LO]});
    assign is_ctr[i] = mode_r[i*DTC_MODE_NIB+DTC_MODE_CT];
    assign gate[i]   = mode_r[i*DTC_MODE_NIB+DTC_MODE_GATE];
    assign run_ok[i] = run_r[i] & (~gate[i] | sync2_r[2+i]);
    assign tick[i]   = fast_r[i] ? at_fast : at_update;
    // a recognised edge counts only at the next update phase
    assign inc[i]    = run_ok[i] & (is_ctr[i] ? (pend_r[i] & at_update)
                                              : tick[i]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // one count step: returns {overflow, high, low}
  function automatic logic [16:0] step(input dtc_mode_t m,
                                       input logic [7:0] hi,
                                       input logic [7:0] lo);
    logic [DTC_LOW_PRE-1:0] pre;
    logic [16:0]            r;
    pre = '0;
    r   = {1'b0, hi, lo};
    case (m)
      DTC_M13: begin
        // low five bits prescale the high byte
        pre = lo[DTC_LOW_PRE-1:0] + 5'h01;
        r   = {1'b0, hi, lo[7:DTC_LOW_PRE], pre};
        if (&lo[DTC_LOW_PRE-1:0]) begin
          r = {&hi, hi + 8'h01, lo[7:DTC_LOW_PRE], pre};
        end
      end
      DTC_M16: begin
        // all ones wraps to zero with the overflow
        r = {&{hi, lo}, {hi, lo} + 16'h0001};
      end
      DTC_M8R: begin
        // low byte reloads from high byte on overflow
        r = (&lo) ? {1'b1, hi, hi} : {1'b0, hi, lo + 8'h01};
      end
      default: begin
        // split: plain 8-bit low byte
        r = {&lo, hi, lo + 8'h01};
      end
    endcase
    return r;
  endfunction

  logic [16:0] nxt0;           // timer 0 step result
  logic [16:0] nxt1;           // timer 1 step result
  logic        split;          // timer 0 in split mode
  logic        th0_inc;        // split-mode high byte of timer 0 ticks
  logic        th0_ovf;        // split-mode high byte overflow
  logic [1:0]  ovf_ev;         // overflow events this clock
  assign nxt0    = step(mode[0], th_r[0], tl_r[0]);
  assign nxt1    = step(mode[1], th_r[1], tl_r[1]);
  assign split   = (mode[0] == DTC_MSPL);
  // in split mode the high byte of timer 0 borrows timer 1's run bit
  assign th0_inc = split & run_r[1] & tick[0];
  assign th0_ovf = th0_inc & (&th_r[0]);
  assign ovf_ev[0] = inc[0] & nxt0[16];
  // timer 1 is halted in its own split mode
  assign ovf_ev[1] = inc[1] & (mode[1] != DTC_MSPL) & nxt1[16];

  ////////////////////////////////////////////////////////////////////////////
  // register write decode
  logic wr_tl0, wr_th0, wr_tl1, wr_th1, wr_ctrl;
  assign wr_tl0  = sfr_req.wr & (sfr_req.addr == DTC_ADDR_TL0);
  assign wr_th0  = sfr_req.wr & (sfr_req.addr == DTC_ADDR_TH0);
  assign wr_tl1  = sfr_req.wr & (sfr_req.addr == DTC_ADDR_TL1);
  assign wr_th1  = sfr_req.wr & (sfr_req.addr == DTC_ADDR_TH1);
  assign wr_ctrl = sfr_req.wr & (sfr_req.addr == DTC_ADDR_CTRL);

  ////////////////////////////////////////////////////////////////////////////
  // timer 0 count bytes: a processor write beats a count in the same clock
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tl_r[0] <= DTC_RST_BYTE;
      th_r[0] <= DTC_RST_BYTE;
    end else if (clk_en) begin
      if (wr_tl0) begin
        tl_r[0] <= sfr_req.wdata;
      end else if (inc[0]) begin
        tl_r[0] <= nxt0[7:0];
      end
      if (wr_th0) begin
        th_r[0] <= sfr_req.wdata;
      end else if (th0_inc) begin
        th_r[0] <= th_r[0] + 8'h01;
      end else if (inc[0] && !split) begin
        th_r[0] <= nxt0[15:8];
      end
    end
  end

  // timer 1 count bytes; a cleared run bit leaves them untouched
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tl_r[1] <= DTC_RST_BYTE;
      th_r[1] <= DTC_RST_BYTE;
    end else if (clk_en) begin
      if (wr_tl1) begin
        tl_r[1] <= sfr_req.wdata;
      end else if (inc[1] && mode[1] != DTC_MSPL) begin
        tl_r[1] <= nxt1[7:0];
      end
      if (wr_th1) begin
        th_r[1] <= sfr_req.wdata;
      end else if (inc[1] && mode[1] != DTC_MSPL) begin
        th_r[1] <= nxt1[15:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mode_r <= DTC_RST_BYTE;
      fast_r <= '0;                                    // divide by 12
      toe_r  <= '0;
      run_r  <= '0;
    end else if (clk_en && sfr_req.wr) begin
      case (sfr_req.addr)
        DTC_ADDR_MODE:  mode_r <= sfr_req.wdata;
        DTC_ADDR_PRESC: begin
          fast_r <= {sfr_req.wdata[DTC_PRESC_FAST1],
                     sfr_req.wdata[DTC_PRESC_FAST0]};
        end
        DTC_ADDR_PCFG: begin
          toe_r <= {sfr_req.wdata[DTC_PCFG_TOE1],
                    sfr_req.wdata[DTC_PCFG_TOE0]};
        end
        DTC_ADDR_CTRL: begin
          run_r <= {sfr_req.wdata[DTC_CTRL_RUN1],
                    sfr_req.wdata[DTC_CTRL_RUN0]};
        end
        default: ;                                     // not ours
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // overflow flags: a hardware set wins over service clear or software write
  logic [1:0] set_ev;          // pin toggle sources
  assign set_ev = {ovf_ev[1] | (split & th0_ovf), ovf_ev[0]};
  // while timer 0 is split, timer 1 still counts but owns no flag
  logic [1:0] set_ok;
  assign set_ok = {split ? th0_ovf : ovf_ev[1], ovf_ev[0]};

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ovf_r <= '0;
    end else if (clk_en) begin
      for (int i = 0; i < 2; i++) begin
        if (set_ok[i]) begin
          ovf_r[i] <= 1'b1;
        end else if (wr_ctrl) begin
          ovf_r[i] <= sfr_req.wdata[DTC_CTRL_OVF0 + 2*i];
        end else if (ovf_service_ack[i]) begin
          ovf_r[i] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // toggle outputs on the count pins
  // while driven, the pin's own level is no longer a valid count source
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tog_r <= '0;
    end else if (clk_en) begin
      for (int i = 0; i < 2; i++) begin
        if (toe_r[i] && set_ev[i]) begin
          tog_r[i] <= ~tog_r[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, registered; unmapped addresses read zero
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= '0;
    end else if (clk_en && sfr_req.rd) begin
      rdata_r <= '0;
      case (sfr_req.addr)
        DTC_ADDR_TL0:   rdata_r <= tl_r[0];
        DTC_ADDR_TH0:   rdata_r <= th_r[0];
        DTC_ADDR_TL1:   rdata_r <= tl_r[1];
        DTC_ADDR_TH1:   rdata_r <= th_r[1];
        DTC_ADDR_MODE:  rdata_r <= mode_r;
        DTC_ADDR_CTRL: begin
          rdata_r[DTC_CTRL_RUN0] <= run_r[0];
          rdata_r[DTC_CTRL_OVF0] <= ovf_r[0];
          rdata_r[DTC_CTRL_RUN1] <= run_r[1];
          rdata_r[DTC_CTRL_OVF1] <= ovf_r[1];
        end
        DTC_ADDR_PRESC: begin
          rdata_r[DTC_PRESC_FAST0] <= fast_r[0];
          rdata_r[DTC_PRESC_FAST1] <= fast_r[1];
        end
        DTC_ADDR_PCFG: begin
          rdata_r[DTC_PCFG_TOE0] <= toe_r[0];
          rdata_r[DTC_PCFG_TOE1] <= toe_r[1];
        end
        default: rdata_r <= '0;                        // unmapped
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flops
  assign sfr_rdata     = rdata_r;
  assign ovf_flag      = ovf_r;
  assign count_pin_out = tog_r;
  assign count_pin_oe  = toe_r;

endmodule // dtc_core

`default_nettype wire

// [sim/dtc_core_assertions.sv]
// checker: port-level properties of the timer pair
`timescale 1ns/100ps
`default_nettype none

module dtc_core_chk
  import dtc_pkg::*;
(
  // clock and reset
  input wire logic         clock,
  input wire logic         rst_b,
  input wire logic         clk_en,
  // register access
  input wire dtc_sfr_req_t sfr_req,
  input wire logic [7:0]   sfr_rdata,
  // flags and pins
  input wire logic [1:0]   ovf_service_ack,
  input wire logic [1:0]   ovf_flag,
  input wire logic [1:0]   count_pin_in,
  input wire logic [1:0]   count_pin_out,
  input wire logic [1:0]   count_pin_oe,
  input wire logic [1:0]   ext_irq_pin
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  logic       wr_c;    // control write taken at this edge
  logic [7:0] presc_s; // shadow of the prescale select
  logic [7:0] mode_s;  // shadow of the mode register
  assign wr_c = clk_en && sfr_req.wr && sfr_req.addr == DTC_ADDR_CTRL;

  // shadows follow accepted writes; reserved prescale bits stay 0
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      presc_s <= 8'h00;
      mode_s  <= 8'h00;
    end else if (clk_en && sfr_req.wr) begin
      if (sfr_req.addr == DTC_ADDR_PRESC) begin
        presc_s <= sfr_req.wdata & 8'h18;
      end
      if (sfr_req.addr == DTC_ADDR_MODE) begin
        mode_s <= sfr_req.wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_flag0_fall;
    $fell(ovf_flag[0]) |-> $past(ovf_service_ack[0]) || $past(wr_c);
  endproperty
  a_flag0_fall: assert property (p_flag0_fall)
    else $error("flag 0 dropped with no clear");
  property p_flag1_fall;
    $fell(ovf_flag[1]) |-> $past(ovf_service_ack[1]) || $past(wr_c);
  endproperty
  a_flag1_fall: assert property (p_flag1_fall)
    else $error("flag 1 dropped with no clear");
  property p_tog0_oe;
    $changed(count_pin_out[0]) |-> $past(count_pin_oe[0]);
  endproperty
  a_tog0_oe: assert property (p_tog0_oe)
    else $error("pin 0 toggled while not enabled");
  property p_tog0_flag;
    $changed(count_pin_out[0]) |-> ovf_flag[0];
  endproperty
  a_tog0_flag: assert property (p_tog0_flag)
    else $error("pin 0 toggled with no overflow flag");
  property p_oe_cfg;
    clk_en && sfr_req.wr && sfr_req.addr == DTC_ADDR_PCFG
      |=> count_pin_oe == $past(sfr_req.wdata[3:2]);
  endproperty
  a_oe_cfg: assert property (p_oe_cfg)
    else $error("toggle enables do not follow write");
  property p_presc_rd;
    clk_en && sfr_req.rd && sfr_req.addr == DTC_ADDR_PRESC
      |=> sfr_rdata == presc_s;
  endproperty
  a_presc_rd: assert property (p_presc_rd)
    else $error("prescale readback wrong");
  property p_mode_rd;
    clk_en && sfr_req.rd && sfr_req.addr == DTC_ADDR_MODE
      |=> sfr_rdata == mode_s;
  endproperty
  a_mode_rd: assert property (p_mode_rd)
    else $error("mode readback wrong");
  property p_hold;
    !(clk_en && sfr_req.rd) |=> $stable(sfr_rdata);
  endproperty
  a_hold: assert property (p_hold)
    else $error("read data moved with no read");
endmodule // dtc_core_chk

bind dtc_core dtc_core_chk chk_i (
  .clock(clock), .rst_b(rst_b), .clk_en(clk_en), .sfr_req(sfr_req),
  .sfr_rdata(sfr_rdata), .ovf_service_ack(ovf_service_ack),
  .ovf_flag(ovf_flag), .count_pin_in(count_pin_in),
  .count_pin_out(count_pin_out), .count_pin_oe(count_pin_oe),
  .ext_irq_pin(ext_irq_pin));

`default_nettype wire

// [sim/dtc_pins_model.sv]
// far side: count pin sources with pull-up, resolved against the device
`timescale 1ns/100ps
`default_nettype none

module dtc_pins_model (
  // clock
  input  wire logic       clock,
  // device side of the count pins
  input  wire logic [1:0] oe,
  input  wire logic [1:0] dout,
  // resolved pin levels
  output var  logic [1:0] pin
);
  logic [1:0] drv = 2'b11; // released source: pull-up holds the line high

  // device wins where it drives, else the source or the pull-up
  always_comb pin = (oe & dout) | (~oe & drv);

  // one falling edge every 24 clocks, the fastest legal rate
  task automatic pulses(input int ch, input int k);
    repeat (k) begin
      @(negedge clock);
      drv[ch] = 1'b0;
      repeat (12) @(negedge clock);
      drv[ch] = 1'b1;
      repeat (11) @(negedge clock);
    end
  endtask
endmodule // dtc_pins_model

`default_nettype wire

// [sim/dtc_core_bench.sv]
// bench: integer model of both timers compared through the registers
`timescale 1ns/100ps
`default_nettype none

module dtc_core_bench;
  import dtc_pkg::*;
  logic         clock = 0;     // 100 MHz
  logic         rst_b = 0;     // held 10 cycles
  dtc_sfr_req_t req   = '0;    // register request
  logic [7:0]   rdata;         // read data
  logic [1:0]   ack   = 0;     // service entry pulses
  logic [1:0]   irq   = 0;     // gate pins
  logic [1:0]   flag, pout, poe, pin;
  logic [1:0]   tog   = 0;     // expected toggle levels
  int           bad_count = 0;
  int           checked   = 0;

  always #5 clock = ~clock;

  dtc_core uut (.clock(clock), .rst_b(rst_b), .clk_en(1'b1),
    .sfr_req(req), .sfr_rdata(rdata), .ovf_service_ack(ack),
    .ovf_flag(flag), .count_pin_in(pin), .count_pin_out(pout),
    .count_pin_oe(poe), .ext_irq_pin(irq));
  dtc_pins_model pm (.clock(clock), .oe(poe), .dout(pout), .pin(pin));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask

  // one access: held across the taking edge, dropped half a cycle later
  task automatic acc(input logic [7:0] a, input logic [7:0] d,
                     input logic w);
    @(negedge clock);
    req = '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge clock);
    @(negedge clock);
    req = '0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e,
                     input logic [7:0] mk);
    acc(a, 8'h00, 1'b0);
    chk(rdata & mk, e);
  endtask

  // reference for one timer over n ticks: {overflows, high, low}
  function automatic int model(int m, int th, int tl, int n);
    int ov = 0;
    for (int i = 0; i < n; i++) begin
      if (m == 2) begin
        // only a reload is an overflow, not a count that meets the high byte
        ov += tl == 'hff ? 1 : 0;
        tl = tl == 'hff ? th : tl + 1;
      end else begin
        tl = (tl + 1) & (m == 0 ? 'h1f : 'hff);
        if (tl == 0 && m != 3) th = (th + 1) & 'hff;
        ov += (tl == 0 && (m == 3 || th == 0)) ? 1 : 0;
        if (m == 3) th = (th + 1) & 'hff;
      end
    end
    return (ov << 16) | (th << 8) | (m == 0 ? tl & 'h1f : tl);
  endfunction

  // load, run exactly 240 clocks, stop, let time pass, compare
  task automatic run_case(input int t, input int m, input int f,
                          input int g, input int n);
    int th, tl, r, mk;
    logic [7:0] lo, hi;
    mk = m == 3 ? 'h7f : 'hff;
    // start near the top so that wraps and reloads really happen
    th = m < 2 ? 'hff : $urandom & mk;
    tl = $urandom & 'hff;
    if (m != 0) tl = tl | 'he0;
    lo = t ? DTC_ADDR_TL1 : DTC_ADDR_TL0;
    hi = t ? DTC_ADDR_TH1 : DTC_ADDR_TH0;
    acc(DTC_ADDR_CTRL, 8'h00, 1);
    acc(DTC_ADDR_PRESC, 8'(f << (3 + t)), 1);
    acc(DTC_ADDR_MODE, 8'(((m | g << 3) << 4 * t) | (t ? 0 : 'h30)), 1);
    acc(hi, 8'(th), 1);
    acc(lo, 8'(tl), 1);
    acc(DTC_ADDR_CTRL, 8'(m == 3 ? 'h50 : 'h10 << 2 * t), 1);
    repeat (239) @(negedge clock);
    // stop, writing the flags back so an earlier overflow survives
    req = '{addr: DTC_ADDR_CTRL, wdata: {flag[1], 1'b0, flag[0], 5'h00},
            wr: 1'b1, rd: 1'b0};
    @(negedge clock);
    req = '0;
    repeat (30) @(negedge clock);
    r = model(m, th, tl, n);
    tog[t] ^= r[16];
    rdc(lo, 8'(r), m == 0 ? 8'h1f : 8'hff);
    rdc(hi, 8'(r >> 8), 8'hff);
    chk(8'(flag[t]), 8'(r >> 16 != 0));
    chk(8'(pout[t]), 8'(tog[t]));
  endtask

  task automatic tally_and_finish();
    if (bad_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs about 3100 clocks
  initial begin
    #200000;
    bad_count++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] v;
    void'($urandom(32'h61be));
    repeat (10) @(negedge clock);
    rst_b = 1;
    for (int a = 'h88; a < 'h90; a++) rdc(8'(a), 8'h00, 8'hff);
    acc(DTC_ADDR_PRESC, 8'hff, 1);
    rdc(DTC_ADDR_PRESC, 8'h18, 8'hff);
    v = 8'($urandom);
    acc(DTC_ADDR_MODE, v, 1);
    rdc(DTC_ADDR_MODE, v, 8'hff);
    acc(DTC_ADDR_PCFG, 8'h0c, 1);
    chk(8'(poe), 8'h03);
    // every mode on timer 0, timer 1 parked in its halt mode
    for (int m = 0; m < 4; m++) run_case(0, m, 0, 0, 20);
    // both timers at both prescale rates, 16-bit wrap with flag
    for (int i = 0; i < 4; i++) begin
      run_case(i / 2, 1, i % 2, 0, 20 + 40 * (i % 2));
    end
    // gate closed, then opened by the interrupt pin
    run_case(0, 1, 0, 1, 0);
    irq = 2'b01;
    run_case(0, 1, 0, 1, 20);
    // software set, then service entry clears one flag only
    acc(DTC_ADDR_CTRL, 8'ha0, 1);
    chk(8'(flag), 8'h03);
    @(negedge clock);
    ack = 2'b01;
    @(negedge clock);
    ack = 2'b00;
    rdc(DTC_ADDR_CTRL, 8'h80, 8'hff);
    // counter function: five pin edges, internal ticks ignored
    acc(DTC_ADDR_PCFG, 8'h00, 1);
    acc(DTC_ADDR_MODE, 8'h35, 1);
    acc(DTC_ADDR_TL0, 8'h00, 1);
    acc(DTC_ADDR_CTRL, 8'h10, 1);
    pm.pulses(0, 5);
    repeat (40) @(negedge clock);
    rdc(DTC_ADDR_TL0, 8'h05, 8'hff);
    tally_and_finish();
  end
endmodule // dtc_core_bench

`default_nettype wire
